// >>> dom_pkg.sv
/*
  Constants, field layout and encodings for the display output mode register.
  Assumes one 250 MHz clock with a synchronous active-low reset, and a plain
  register port with byte addresses.
*/
`default_nettype none
package dom_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int DOM_ADDR_W = 12;
  localparam int DOM_DATA_W = 8;
  localparam logic [DOM_ADDR_W-1:0] DOM_MODE_OFF = 12'h01fc;
  localparam logic [DOM_DATA_W-1:0] DOM_MODE_RESET = 8'h00;
  // only bits 6 and 2..0 store anything
  localparam logic [DOM_DATA_W-1:0] DOM_MODE_WMASK = 8'h47;
  localparam int DOM_SEL_LSB = 0;
  localparam int DOM_SEL_MSB = 2;
  localparam int DOM_ROT_LOW_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // display select codes
  typedef enum logic [2:0] {
    DOM_SEL_NONE = 3'h0,
    DOM_SEL_PANEL = 3'h1,
    DOM_SEL_CRT = 3'h2,
    DOM_SEL_CRT_PANEL = 3'h3,
    DOM_SEL_TV = 3'h4,
    DOM_SEL_TV_PANEL = 3'h5,
    DOM_SEL_TVF = 3'h6,
    DOM_SEL_TVF_PANEL = 3'h7
  } dom_sel_e;

  // rotation codes, {high, low}
  typedef enum logic [1:0] {
    DOM_ROT_0 = 2'h0,
    DOM_ROT_90 = 2'h1,
    DOM_ROT_180 = 2'h2,
    DOM_ROT_270 = 2'h3
  } dom_rot_e;

  ////////////////////////////////////////////////////////////////////////////
  // tv line store defaults
  localparam int DOM_PIX_W = 8;
  localparam int DOM_LINE_DEPTH = 1024;

endpackage : dom_pkg
`default_nettype wire

// >>> dom_line_mem.sv
/*
  Single line store for the flicker filter: one write port, one read port,
  read data registered.  Assumes the caller keeps addresses below DEPTH.
*/
`timescale 1ns/10ps
`default_nettype none
module dom_line_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1024,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rd_q;

  // read-first: same-address write returns the previous line's pixel
  always_ff @(posedge clk)
  begin
    rd_q <= mem[rd_addr];
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = rd_q;

endmodule : dom_line_mem
`default_nettype wire

// >>> dom_mode_select.sv
/*
  Display output mode register with output enables, rotation code and
  the tv flicker filter datapath.  Assumes a same-clock register master
  and a same-clock tv pixel stream with start-of-line/frame marks.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module dom_mode_select #(
  parameter int PIX_W = dom_pkg::DOM_PIX_W,
  parameter int LINE_DEPTH = dom_pkg::DOM_LINE_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [dom_pkg::DOM_ADDR_W-1:0] reg_addr,
  input wire logic [dom_pkg::DOM_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dom_pkg::DOM_DATA_W-1:0] reg_rdata,
  // high rotate bit from the other register
  input wire logic rotate_enable_high,
  // output enables
  output logic panel_en,
  output logic crt_en,
  output logic tv_en,
  output logic flicker_en,
  output logic simultaneous_dual_output,
  output logic [1:0] rotate_mode,
  // tv pixel stream in
  input wire logic tv_in_valid,
  input wire logic tv_in_sol,
  input wire logic tv_in_sof,
  input wire logic [PIX_W-1:0] tv_in_data,
  // tv pixel stream out
  output logic tv_out_valid,
  output logic [PIX_W-1:0] tv_out_data
);
  import dom_pkg::*;

  localparam int AW = $clog2(LINE_DEPTH);

  // enables {dual, flicker, tv, crt, panel} from a select code
  function automatic logic [4:0] sel_decode(input logic [2:0] sel);
    logic panel;
    logic crt;
    logic tv;
    logic flt;
    logic dual;
    panel = sel[0];
    crt = (sel == DOM_SEL_CRT) || (sel == DOM_SEL_CRT_PANEL);
    tv = sel[2];
    flt = sel[2] & sel[1];
    dual = panel & (crt | tv);
    sel_decode = {dual, flt, tv, crt, panel};
  endfunction : sel_decode

  // halves the sum without losing the carry
  function automatic logic [PIX_W-1:0] pix_avg(input logic [PIX_W-1:0] a,
                                                input logic [PIX_W-1:0] b);
    logic [PIX_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    pix_avg = sum[PIX_W:1];
  endfunction : pix_avg

  //////////////////////////////////////////////////////////////////////////
  // register and output enables
  logic [DOM_DATA_W-1:0] mode_q, mode_d;
  logic [DOM_DATA_W-1:0] rdata_q, rdata_d;
  logic [4:0] en_q, en_d;
  logic [1:0] rot_q, rot_d;
  logic hit;

  assign hit = (reg_addr == DOM_MODE_OFF);

  // next register state; outputs follow the new value with no extra lag
  always_comb
  begin
    mode_d = mode_q;
    if (reg_wr && hit)
    begin
      mode_d = reg_wdata & DOM_MODE_WMASK;
    end
    // read data live only in the cycle after the strobe
    rdata_d = '0;
    if (reg_rd && hit)
    begin
      rdata_d = mode_q & DOM_MODE_WMASK;
    end
    en_d = sel_decode(mode_d[DOM_SEL_MSB:DOM_SEL_LSB]);
    rot_d = {rotate_enable_high, mode_d[DOM_ROT_LOW_BIT]};
  end

  // register stage; reset leaves every output off and unrotated
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mode_q <= DOM_MODE_RESET;
      rdata_q <= '0;
      en_q <= '0;
      rot_q <= DOM_ROT_0;
    end
    else
    begin
      mode_q <= mode_d;
      rdata_q <= rdata_d;
      en_q <= en_d;
      rot_q <= rot_d;
    end
  end

  // every register-side port comes straight from a flop
  assign reg_rdata = rdata_q;
  assign panel_en = en_q[0];
  assign crt_en = en_q[1];
  assign tv_en = en_q[2];
  assign flicker_en = en_q[3];
  assign simultaneous_dual_output = en_q[4];
  assign rotate_mode = rot_q;

  //////////////////////////////////////////////////////////////////////////
  // tv flicker filter
  logic [AW-1:0] x_q, x_d;
  logic [AW-1:0] x_cur;
  logic first_q, first_d;
  logic [PIX_W-1:0] pix_q, pix_d;
  logic pv_q, pv_d;
  logic filt_q, filt_d;
  logic ov_q, ov_d;
  logic [PIX_W-1:0] od_q, od_d;
  logic [PIX_W-1:0] prev_pix;

  // pixel column restarts on each line mark
  // limitation: lines longer than LINE_DEPTH wrap and blend the wrong column
  assign x_cur = tv_in_sol ? '0 : x_q;

  dom_line_mem #(
    .WIDTH(PIX_W),
    .DEPTH(LINE_DEPTH),
    .AW(AW)
  ) u_line (
    .clk(clk),
    .wr_en(tv_in_valid),
    .wr_addr(x_cur),
    .wr_data(tv_in_data),
    .rd_addr(x_cur),
    .rd_data(prev_pix)
  );

  // first line of a frame has no line above it, so it passes unfiltered
  always_comb
  begin
    x_d = x_q;
    first_d = first_q;
    if (tv_in_valid)
    begin
      x_d = x_cur + 1'b1;
      if (tv_in_sof)
      begin
        first_d = 1'b1;
      end
      else if (tv_in_sol)
      begin
        first_d = 1'b0;
      end
    end
    pv_d = tv_in_valid & tv_en;
    pix_d = tv_in_data;
    filt_d = flicker_en & ~(tv_in_sof | (first_q & ~tv_in_sol));
    ov_d = pv_q;
    od_d = od_q;
    if (pv_q)
    begin
      od_d = filt_q ? pix_avg(pix_q, prev_pix) : pix_q;
    end
  end

  // stream stage; a reset mid-frame waits for the next line mark to filter again
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      x_q <= '0;
      first_q <= 1'b1;
      pix_q <= '0;
      pv_q <= 1'b0;
      filt_q <= 1'b0;
      ov_q <= 1'b0;
      od_q <= '0;
    end
    else
    begin
      x_q <= x_d;
      first_q <= first_d;
      pix_q <= pix_d;
      pv_q <= pv_d;
      filt_q <= filt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end

  // output pixel and its strobe leave from flops
  assign tv_out_valid = ov_q;
  assign tv_out_data = od_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // rotation code: low bit stored here, high bit from the neighbour register
  property p_rot_low;
    reg_wr && hit |=> rotate_mode[0] == $past(reg_wdata[DOM_ROT_LOW_BIT]);
  endproperty
  a_rot_low: assert property (p_rot_low) else $error("rotate low bit not taken");

  property p_rot_pair;
    $past(rst_b) |-> rotate_mode == {$past(rotate_enable_high), mode_q[DOM_ROT_LOW_BIT]};
  endproperty
  a_rot_pair: assert property (p_rot_pair) else $error("rotation code wrong");

  // enables against the stored select code
  property p_crt;
    $past(rst_b) |-> crt_en == (mode_q[2:0] == 3'h2 || mode_q[2:0] == 3'h3) &&
      simultaneous_dual_output == (mode_q[0] && mode_q[2:1] != 2'h0);
  endproperty
  a_crt: assert property (p_crt) else $error("crt or dual enable wrong");

  property p_tv;
    reg_wr && hit |=> tv_en == $past(reg_wdata[2]) &&
      flicker_en == ($past(reg_wdata[2:1]) == 2'h3);
  endproperty
  a_tv: assert property (p_tv) else $error("tv or filter enable wrong");

  property p_panel;
    $past(rst_b) |-> panel_en == mode_q[0];
  endproperty
  a_panel: assert property (p_panel) else $error("panel enable wrong");

  // tv path: two cycles of latency, pass-through or average
  property p_filt_off;
    tv_out_valid && !$past(filt_q) |-> tv_out_data == $past(tv_in_data, 2);
  endproperty
  a_filt_off: assert property (p_filt_off) else $error("unfiltered pixel altered");

  property p_filt_on;
    tv_out_valid && $past(filt_q) |->
      (tv_out_data >= $past(pix_q) || tv_out_data >= $past(prev_pix)) &&
      (tv_out_data <= $past(pix_q) || tv_out_data <= $past(prev_pix));
  endproperty
  a_filt_on: assert property (p_filt_on) else $error("filtered pixel not averaged");

  property p_unused_bits;
    reg_rd && hit |=> reg_rdata[7] == 1'b0 && reg_rdata[5:3] == 3'h0 &&
      reg_rdata == $past(mode_q);
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused bits not zero");

  // read data stand one cycle only; unmapped reads answer zero
  property p_rdata_idle;
    !(reg_rd && hit) |=> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  // enables and register hold unless the mapped address is written
  property p_hold;
    !(reg_wr && hit) |=> $stable(mode_q) && $stable(en_q);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without a write");

  // high rotate bit is taken one cycle late, like the stored bit
  property p_rot_high;
    rotate_enable_high |=> rotate_mode[1];
  endproperty
  a_rot_high: assert property (p_rot_high) else $error("rotate high bit not taken");

  // reset leaves every output idle; watched through reset itself
  property p_reset_clear;
    disable iff (1'b0)
    !rst_b |=> reg_rdata == '0 && en_q == '0 && rotate_mode == DOM_ROT_0 &&
      !tv_out_valid && mode_q == DOM_MODE_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset not clean");

  // tv pixels come out only while the tv output was enabled
  property p_tv_gate;
    tv_out_valid |-> $past(tv_en, 2);
  endproperty
  a_tv_gate: assert property (p_tv_gate) else $error("tv pixel while tv off");

  // averaging only under a filter code, never on a frame's opening pixel
  property p_filt_sel;
    tv_out_valid && $past(filt_q) |-> $past(flicker_en, 2) && !$past(tv_in_sof, 2);
  endproperty
  a_filt_sel: assert property (p_filt_sel) else $error("filter outside its code");

  // scenarios worth seeing: dual with filter, 270 degrees, averaging, reads, refused writes
  c_dual_tvf: cover property (reg_wr && hit && reg_wdata[2:0] == 3'h7);
  c_rot_270: cover property (rotate_mode == DOM_ROT_270);
  c_filtered: cover property (tv_out_valid && $past(filt_q));
  c_read: cover property (reg_rd && hit ##1 reg_rdata != '0);
  c_unmapped_wr: cover property (reg_wr && !hit);

endmodule : dom_mode_select
`default_nettype wire

// >>> display_output_mode_select_tb.sv
/*
  Bench for the display output mode register and its tv stream.
  Assumes dom_pkg and dom_mode_select are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module display_output_mode_select_tb;
  import dom_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, rot_hi, tv_v, tv_sol, tv_sof, tv_ov;
  logic [DOM_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, tv_d, tv_od;
  logic panel_en, crt_en, tv_en, flicker_en, dual;
  logic [1:0] rotate_mode;
  logic [7:0] outq[$];
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  // short line store keeps the run small
  dom_mode_select #(.PIX_W(8), .LINE_DEPTH(16)) DUT (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rotate_enable_high(rot_hi), .panel_en(panel_en), .crt_en(crt_en),
    .tv_en(tv_en), .flicker_en(flicker_en), .simultaneous_dual_output(dual),
    .rotate_mode(rotate_mode), .tv_in_valid(tv_v), .tv_in_sol(tv_sol),
    .tv_in_sof(tv_sof), .tv_in_data(tv_d), .tv_out_valid(tv_ov),
    .tv_out_data(tv_od));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // collect output pixels; old values are seen at the edge
  always @(posedge clk)
  begin
    cyc++;
    if (tv_ov === 1'b1)
      outq.push_back(tv_od);
    if (cyc == 3000)
    begin
      error_cnt++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("read data", reg_rdata, exp);
  endtask : rd

  task automatic pix(input logic [7:0] d, input logic sol, input logic sof);
    @(posedge clk);
    tv_v <= 1'b1;
    tv_d <= d;
    tv_sol <= sol;
    tv_sof <= sof;
  endtask : pix

  // two lines; second one averaged only when the filter is on
  task automatic stream(input logic [7:0] m);
    logic [7:0] a[4] = '{8'h10, 8'h20, 8'hff, 8'h00};
    logic [7:0] b[4] = '{8'h30, 8'h21, 8'hff, 8'hff};
    logic [8:0] s;
    wr(DOM_MODE_OFF, m);
    outq.delete();
    for (int i = 0; i < 4; i++)
      pix(a[i], i == 0, i == 0);
    for (int i = 0; i < 4; i++)
      pix(b[i], i == 0, 1'b0);
    // let the last pixel's edge pass before dropping valid
    @(posedge clk);
    tv_v <= 1'b0;
    repeat (4) @(posedge clk);
    check("tv count", 8'(outq.size()), m[2] ? 8'h08 : 8'h00);
    for (int i = 0; i < 4 && m[2]; i++)
    begin
      s = {1'b0, a[i]} + {1'b0, b[i]};
      check("tv line a", outq[i], a[i]);
      check("tv line b", outq[i+4], m[1] ? s[8:1] : b[i]);
    end
  endtask : stream

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] m, e, got;
    {reg_addr, reg_wdata, reg_wr, reg_rd, rot_hi} = '0;
    {tv_v, tv_sol, tv_sof, tv_d} = '0;
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(DOM_MODE_OFF, DOM_MODE_RESET);
    // every select code, with the unused bits written high
    for (int c = 0; c < 8; c++)
    begin
      m = 8'(c);
      wr(DOM_MODE_OFF, m | 8'hb8);
      got = {3'b0, panel_en, crt_en, tv_en, flicker_en, dual};
      e = {3'b0, m[0], m[2:1] == 2'b01, m[2], m[2:1] == 2'b11, m == 3 || m == 5 || m == 7};
      check("enables", got, e);
      rd(DOM_MODE_OFF, m);
    end
    // unmapped places neither store nor answer
    wr(12'h1fd, 8'h40);
    rd(12'h1fd, 8'h00);
    rd(DOM_MODE_OFF, 8'h07);
    // all four rotation codes
    for (int r = 0; r < 4; r++)
    begin
      @(posedge clk);
      rot_hi <= r[1];
      wr(DOM_MODE_OFF, {1'b0, r[0], 6'h01});
      @(posedge clk);
      #1 check("rotation", {6'b0, rotate_mode}, 8'(r));
      rd(DOM_MODE_OFF, {1'b0, r[0], 6'h01});
    end
    // mid-run reset: register, enables and rotation go back to idle
    @(posedge clk);
    rst_b <= 1'b0;
    rot_hi <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 got = {3'b0, panel_en, crt_en, tv_en, flicker_en, dual};
    check("reset enables", got, 8'h00);
    check("reset rotation", {6'b0, rotate_mode}, 8'h00);
    rd(DOM_MODE_OFF, DOM_MODE_RESET);
    // each stream writes its own code: filter on, tv alone, then tv off
    stream(8'h06);
    stream(8'h04);
    stream(8'h01);
    final_report();
  end
endmodule : display_output_mode_select_tb
`default_nettype wire
